// ==== rtl/pdr_pkg.sv ====
//==========================================================
// Notes on behaviour
// - Hold servo-on through dip, 20..65535 ms
// - Ride through if dip not longer than hold
// - Resupply motor when main supply recovers
// - Drop servo-ready when hold expires
// - Control supply failure acts as power-off
// - Undervoltage alarm overrides hold setting
// - Undervoltage select 0/1/2, applied at restart
// - Warn when DC bus at or below threshold
// - Internal clamp percent 0..100, default 50
// - Keep clamp for release time after warning
// - Servo-off command cuts motor power immediately
// - Max speed settings, applied at restart
// - Overspeed alarm when speed exceeds maximum
// - Lower linear max raises resolution bound
package pdr_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HOLD = 8'h04;
    localparam logic [7:0] OFS_UVSEL = 8'h08;
    localparam logic [7:0] OFS_TLIM = 8'h0c;
    localparam logic [7:0] OFS_REL = 8'h10;
    localparam logic [7:0] OFS_RMAX = 8'h14;
    localparam logic [7:0] OFS_LMAX = 8'h18;
    localparam logic [7:0] OFS_UVTHR = 8'h1c;
    localparam logic [7:0] OFS_SPEED = 8'h20;
    localparam logic [7:0] OFS_STAT = 8'h24;
    localparam logic [7:0] OFS_ENCMAX = 8'h28;
    // Control register bits
    localparam int CTRL_SERVO_ON = 0;
    localparam int CTRL_LINEAR = 1;
    // Status register bits
    localparam int ST_MOTOR_PWR = 0;
    localparam int ST_READY = 1;
    localparam int ST_UV_WARN = 2;
    localparam int ST_CLAMP = 3;
    localparam int ST_OVERSPEED = 4;
    localparam int ST_UV_ALARM = 5;
    localparam int ST_RIDING = 6;
    // Reset values and limits
    localparam logic [15:0] HOLD_RST = 16'h0014;
    localparam logic [15:0] HOLD_MIN = 16'h0014;
    localparam logic [1:0] UVSEL_RST = 2'h0;
    localparam logic [6:0] TLIM_RST = 7'h32;
    localparam logic [6:0] TLIM_MAX = 7'h64;
    localparam logic [9:0] REL_RST = 10'h064;
    localparam logic [9:0] REL_MAX = 10'h3e8;
    localparam logic [15:0] RMAX_RST = 16'h2710;
    localparam logic [6:0] LMAX_RST = 7'h32;
    localparam logic [6:0] LMAX_MIN = 7'h01;
    localparam logic [6:0] LMAX_MAX = 7'h64;
    localparam logic [15:0] UVTHR_RST = 16'h0000;
    // Encoder resolution bound scale: bound = ENC_SCALE / linear max
    localparam logic [31:0] ENC_SCALE = 32'h0000_1388;
    // Undervoltage handling modes
    typedef enum logic [1:0] {
        UV_OFF = 2'b00,
        UV_HOST = 2'b01,
        UV_DEVICE = 2'b10
    } pdr_uv_t;
    // Ride-through states
    typedef enum logic [1:0] {
        PS_OFF = 2'b00,
        PS_ON = 2'b01,
        PS_HOLD = 2'b10,
        PS_LOST = 2'b11
    } pdr_pwr_t;
endpackage

// ==== rtl/pdr_if.sv ====
`timescale 1ns/1ps
// Millisecond tick shared between the supervisor and its tick source
interface pdr_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// ==== rtl/pdr_ms_tick.sv ====
`timescale 1ns/1ps
//==========================================================
// Millisecond tick divider
module pdr_ms_tick import pdr_pkg::*; #(
    parameter int unsigned DIV = CYC_PER_MS
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    pdr_tick_if.src t
);
    if (DIV < 2) begin : g_div_chk
        $error("DIV too small");
    end
    logic [31:0] cnt_reg; // Cycle counter
    logic [31:0] cnt_next;
    // Wrap after DIV cycles
    always_comb begin
        if (cnt_reg == DIV - 1) begin
            cnt_next = 32'h0;
        end else begin
            cnt_next = cnt_reg + 32'h1;
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    assign t.tick = (cnt_reg == DIV - 1);
endmodule // pdr_ms_tick

// ==== rtl/pdr_dip_supervisor.sv ====
`timescale 1ns/1ps
//==========================================================
// Power dip ride-through and speed supervisor
module pdr_dip_supervisor import pdr_pkg::*; #(
    parameter int unsigned MS_DIV = CYC_PER_MS
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Classic Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Supply monitors and restart (asynchronous pins)
    input wire logic i_main_ok,
    input wire logic i_ctrl_ok,
    input wire logic i_uv_alarm,
    input wire logic i_restart,
    // Servo-off command from network side, same clock
    input wire logic i_servo_off_command,
    // Measured values, same clock
    input wire logic [15:0] i_dc_bus,
    input wire logic [15:0] i_speed,
    // Drive outputs
    output logic o_motor_power,
    output logic o_servo_ready,
    output logic o_uv_warning,
    output logic o_torque_clamp,
    output logic [6:0] o_torque_limit_pct,
    output logic o_overspeed_alarm
);
    if (MS_DIV < 2) begin : g_div_chk
        $error("MS_DIV too small");
    end

    //==========================================================
    // Pin synchronisers
    logic [3:0] s1_reg; // First stage, read by second only
    logic [3:0] s2_reg;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_reg <= 4'h0;
            s2_reg <= 4'h0;
        end else begin
            s1_reg <= {i_restart, i_uv_alarm, i_ctrl_ok, i_main_ok};
            s2_reg <= s1_reg;
        end
    end
    logic main_ok, ctrl_ok, uv_alarm, restart;
    assign {restart, uv_alarm, ctrl_ok, main_ok} = s2_reg;

    //==========================================================
    // Millisecond tick
    pdr_tick_if tk ();
    pdr_ms_tick #(.DIV(MS_DIV)) u_tick (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .t(tk)
    );

    //==========================================================
    // Register file
    logic [1:0] ctrl_reg, ctrl_next; // Servo-on request, linear motor
    logic [15:0] hold_reg, hold_next;
    logic [1:0] uvsel_reg, uvsel_next; // Pending selection
    logic [1:0] uvact_reg, uvact_next; // Active selection
    logic [6:0] tlim_reg, tlim_next;
    logic [9:0] rel_reg, rel_next;
    logic [15:0] rmax_reg, rmax_next, rmax_act_reg, rmax_act_next;
    logic [6:0] lmax_reg, lmax_next, lmax_act_reg, lmax_act_next;
    logic [15:0] uvthr_reg, uvthr_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [6:0] status;
    logic [31:0] enc_bound;

    // Byte-lane write merge; unselected bytes keep their old value
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
        wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    logic wr_go, rd_go;
    assign wr_go = i_wb_cyc && i_wb_stb && i_wb_we && !ack_reg;
    assign rd_go = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_reg;

    // Linear max lowering raises encoder resolution ceiling
    assign enc_bound = ENC_SCALE / {25'h0, lmax_act_reg};

    // Register next values and read mux
    always_comb begin
        logic [15:0] v;
        v = 16'h0;
        ctrl_next = ctrl_reg;
        hold_next = hold_reg;
        uvsel_next = uvsel_reg;
        uvact_next = uvact_reg;
        tlim_next = tlim_reg;
        rel_next = rel_reg;
        rmax_next = rmax_reg;
        lmax_next = lmax_reg;
        rmax_act_next = rmax_act_reg;
        lmax_act_next = lmax_act_reg;
        uvthr_next = uvthr_reg;
        ack_next = i_wb_cyc && i_wb_stb && !ack_reg;
        rdat_next = 32'h0;
        if (wr_go) begin
            case (i_wb_adr)
                OFS_CTRL: begin
                    if (i_wb_sel[0]) ctrl_next = i_wb_dat[1:0];
                end
                OFS_HOLD: begin
                    v = wr16(hold_reg, i_wb_dat, i_wb_sel);
                    hold_next = (v < HOLD_MIN) ? HOLD_MIN : v;
                end
                OFS_UVSEL: begin
                    // Value 3 is not a mode; keep old value
                    if (i_wb_sel[0] && i_wb_dat[1:0] != 2'h3) uvsel_next = i_wb_dat[1:0];
                end
                OFS_TLIM: begin
                    // Takes effect immediately
                    if (i_wb_sel[0]) begin
                        tlim_next = (i_wb_dat[6:0] > TLIM_MAX) ? TLIM_MAX : i_wb_dat[6:0];
                    end
                end
                OFS_REL: begin
                    v = wr16({6'h0, rel_reg}, i_wb_dat, i_wb_sel);
                    rel_next = (v > {6'h0, REL_MAX}) ? REL_MAX : v[9:0];
                end
                OFS_RMAX: rmax_next = wr16(rmax_reg, i_wb_dat, i_wb_sel);
                OFS_LMAX: begin
                    if (i_wb_sel[0]) begin
                        if (i_wb_dat[6:0] < LMAX_MIN) lmax_next = LMAX_MIN;
                        else if (i_wb_dat[6:0] > LMAX_MAX) lmax_next = LMAX_MAX;
                        else lmax_next = i_wb_dat[6:0];
                    end
                end
                OFS_UVTHR: uvthr_next = wr16(uvthr_reg, i_wb_dat, i_wb_sel);
                default: ; // Unmapped or read-only: write ignored, still acked
            endcase
        end
        if (rd_go) begin
            case (i_wb_adr)
                OFS_CTRL: rdat_next = {30'h0, ctrl_reg};
                OFS_HOLD: rdat_next = {16'h0, hold_reg};
                OFS_UVSEL: rdat_next = {28'h0, uvact_reg, uvsel_reg};
                OFS_TLIM: rdat_next = {25'h0, tlim_reg};
                OFS_REL: rdat_next = {22'h0, rel_reg};
                OFS_RMAX: rdat_next = {16'h0, rmax_reg};
                OFS_LMAX: rdat_next = {25'h0, lmax_reg};
                OFS_UVTHR: rdat_next = {16'h0, uvthr_reg};
                OFS_SPEED: rdat_next = {16'h0, i_speed};
                OFS_STAT: rdat_next = {25'h0, status};
                OFS_ENCMAX: rdat_next = enc_bound;
                default: rdat_next = 32'h0; // Unmapped reads zero
            endcase
        end
        // Restart-effective settings latch on restart strobe
        if (restart) begin
            uvact_next = uvsel_reg;
            rmax_act_next = rmax_reg;
            lmax_act_next = lmax_reg;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= 2'h0;
            hold_reg <= HOLD_RST;
            uvsel_reg <= UVSEL_RST;
            uvact_reg <= UVSEL_RST;
            tlim_reg <= TLIM_RST;
            rel_reg <= REL_RST;
            rmax_reg <= RMAX_RST;
            lmax_reg <= LMAX_RST;
            rmax_act_reg <= RMAX_RST;
            lmax_act_reg <= LMAX_RST;
            uvthr_reg <= UVTHR_RST;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            hold_reg <= hold_next;
            uvsel_reg <= uvsel_next;
            uvact_reg <= uvact_next;
            tlim_reg <= tlim_next;
            rel_reg <= rel_next;
            rmax_reg <= rmax_next;
            lmax_reg <= lmax_next;
            rmax_act_reg <= rmax_act_next;
            lmax_act_reg <= lmax_act_next;
            uvthr_reg <= uvthr_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    //==========================================================
    // Ride-through state machine
    pdr_pwr_t st_reg, st_next;
    logic [15:0] dip_ms_reg, dip_ms_next; // Interruption time in ms
    logic ready_reg, ready_next;

    always_comb begin
        st_next = st_reg;
        dip_ms_next = dip_ms_reg;
        ready_next = ready_reg;
        case (st_reg)
            PS_OFF: begin
                ready_next = main_ok && ctrl_ok;
                if (ctrl_reg[CTRL_SERVO_ON] && main_ok && ctrl_ok && !uv_alarm) begin
                    st_next = PS_ON;
                end
            end
            PS_ON: begin
                if (!main_ok) begin
                    st_next = PS_HOLD;
                    dip_ms_next = 16'h0;
                end
            end
            PS_HOLD: begin
                if (main_ok) begin
                    st_next = PS_ON;
                end else if (tk.tick) begin
                    // Count whole ms; expire only once strictly longer than hold
                    if (dip_ms_reg >= hold_reg) begin
                        st_next = PS_LOST;
                        ready_next = 1'b0;
                    end else begin
                        dip_ms_next = dip_ms_reg + 16'h1;
                    end
                end
            end
            PS_LOST: begin
                // Resupply on recovery while servo-on still requested
                if (main_ok) begin
                    st_next = PS_ON;
                    ready_next = 1'b1;
                end
            end
            default: st_next = PS_OFF;
        endcase
        // Overrides: servo-off, control failure, undervoltage alarm
        if (i_servo_off_command || !ctrl_reg[CTRL_SERVO_ON]) begin
            st_next = PS_OFF;
        end
        if (!ctrl_ok) begin
            st_next = PS_OFF;
            ready_next = 1'b0;
        end
        if (uv_alarm) begin
            st_next = PS_OFF;
            ready_next = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= PS_OFF;
            dip_ms_reg <= 16'h0;
            ready_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            dip_ms_reg <= dip_ms_next;
            ready_reg <= ready_next;
        end
    end
    // Motor kept energised while on or riding through
    assign o_motor_power = (st_reg == PS_ON) || (st_reg == PS_HOLD);
    assign o_servo_ready = ready_reg;

    //==========================================================
    // Undervoltage warning, torque clamp, overspeed
    logic warn_reg, warn_next;
    logic clamp_reg, clamp_next;
    logic [9:0] rel_ms_reg, rel_ms_next; // Release timer in ms
    logic os_reg, os_next;
    logic [15:0] max_speed;

    // Linear max is in 100 mm/s units, speed input assumed mm/s there
    // Widen before the product, a 7-bit product would wrap
    assign max_speed = ctrl_reg[CTRL_LINEAR] ? 16'(lmax_act_reg) * 16'd100 : rmax_act_reg;

    always_comb begin
        warn_next = (uvact_reg != UV_OFF) && (i_dc_bus <= uvthr_reg);
        clamp_next = clamp_reg;
        rel_ms_next = rel_ms_reg;
        if (uvact_reg == UV_DEVICE && warn_reg) begin
            clamp_next = 1'b1;
            rel_ms_next = 10'h0;
        end else if (clamp_reg) begin
            if (uvact_reg != UV_DEVICE || rel_ms_reg >= rel_reg) begin
                clamp_next = 1'b0;
            end else if (tk.tick) begin
                rel_ms_next = rel_ms_reg + 10'h1;
            end
        end
        os_next = i_speed > max_speed;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            warn_reg <= 1'b0;
            clamp_reg <= 1'b0;
            rel_ms_reg <= 10'h0;
            os_reg <= 1'b0;
        end else begin
            warn_reg <= warn_next;
            clamp_reg <= clamp_next;
            rel_ms_reg <= rel_ms_next;
            os_reg <= os_next;
        end
    end
    // Host mode reports the warning; host does the limiting
    assign o_uv_warning = warn_reg;
    assign o_torque_clamp = clamp_reg;
    assign o_torque_limit_pct = clamp_reg ? tlim_reg : TLIM_MAX;
    assign o_overspeed_alarm = os_reg;
    assign status = {st_reg == PS_HOLD, uv_alarm, os_reg, clamp_reg, warn_reg,
                     ready_reg, o_motor_power};
endmodule // pdr_dip_supervisor

// ==== verif/pdr_dip_supervisor_chk.sv ====
`timescale 1ns/1ps
//==========================================================
// Port-level checks for the dip supervisor
module pdr_chk import pdr_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_main_ok,
    input wire logic i_ctrl_ok,
    input wire logic i_uv_alarm,
    input wire logic i_servo_off_command,
    input wire logic o_motor_power,
    input wire logic o_uv_warning,
    input wire logic o_torque_clamp,
    input wire logic [6:0] o_torque_limit_pct
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    //==========================================================
    // Bus handshake steps and dip start
    sequence wb_req_s;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence wb_ans_s;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    sequence ride_start_s;
        $fell(i_main_ok) && o_motor_power && i_ctrl_ok && !i_uv_alarm && !i_servo_off_command;
    endsequence
    // One wait state, then a one-cycle answer
    ack_timing_a: assert property (wb_req_s |=> wb_ans_s)
        else $error("bus answer late or stretched");
    // Reads past the last register return zero
    unmapped_rd_a: assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) > OFS_ENCMAX
        |-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
    //==========================================================
    // Motor power
    off_cmd_a: assert property (i_servo_off_command |=> !o_motor_power)
        else $error("motor kept on after servo-off");
    // Two sync stages plus the state edge, so four samples
    ctrl_fail_a: assert property (!i_ctrl_ok [*4] |-> !o_motor_power)
        else $error("motor kept on without control supply");
    uv_alarm_a: assert property (i_uv_alarm [*4] |-> !o_motor_power)
        else $error("motor kept on during undervoltage alarm");
    // Hold time is at least 20 ms, so a fresh dip never cuts power
    ride_start_a: assert property (ride_start_s |=> o_motor_power [*4])
        else $error("motor dropped at start of dip");
    power_on_a: assert property ($rose(o_motor_power) |-> !$past(i_servo_off_command))
        else $error("motor rose under servo-off");
    //==========================================================
    // Torque clamp
    torque_full_a: assert property (!o_torque_clamp |-> o_torque_limit_pct == TLIM_MAX)
        else $error("limit below full while unclamped");
    // Clamp follows the warning by one cycle, which may already have cleared
    clamp_cause_a: assert property ($rose(o_torque_clamp) |-> $past(o_uv_warning))
        else $error("clamp rose without warning");
endmodule // pdr_chk

bind pdr_dip_supervisor pdr_chk u_chk (
    .i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack,
    .i_main_ok, .i_ctrl_ok, .i_uv_alarm, .i_servo_off_command, .o_motor_power,
    .o_uv_warning, .o_torque_clamp, .o_torque_limit_pct
);

// ==== verif/pdr_host_model.sv ====
`timescale 1ns/1ps
//==========================================================
// Host motion controller stand-in on the command side
module pdr_host_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_off_req, // Bench asks for servo-off
    input wire logic i_host_mode, // Host owns torque limiting
    input wire logic i_uv_warning,
    output logic o_servo_off_command,
    output logic o_host_tlim // Host-side limit engaged
);
    //==========================================================
    // Command registers, one cycle of network latency
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_servo_off_command <= 1'b0;
            o_host_tlim <= 1'b0;
        end else begin
            o_servo_off_command <= i_off_req;
            o_host_tlim <= i_host_mode & i_uv_warning;
        end
    end
endmodule // pdr_host_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
//==========================================================
// Self-checking bench for the dip supervisor
module tb_top import pdr_pkg::*;;
    localparam int MS = 10; // Short millisecond keeps the run brief
    logic i_ref_clk, i_rst, cyc, stb, we, main_ok, ctrl_ok, uv_alarm, restart, off_req;
    logic host_mode, ack, motor, ready, uvw, clamp, osp, servo_off_command, host_tlim;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, rd_val;
    logic [15:0] dc_bus, speed;
    logic [6:0] tpct;
    int num_errors, cmp_count, seed, hold, tlim, rmax, i, m, s;
    pdr_dip_supervisor #(.MS_DIV(MS)) uut (
        .i_ref_clk, .i_rst, .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_main_ok(main_ok),
        .i_ctrl_ok(ctrl_ok), .i_uv_alarm(uv_alarm), .i_restart(restart),
        .i_servo_off_command(servo_off_command), .i_dc_bus(dc_bus), .i_speed(speed),
        .o_motor_power(motor), .o_servo_ready(ready), .o_uv_warning(uvw),
        .o_torque_clamp(clamp), .o_torque_limit_pct(tpct), .o_overspeed_alarm(osp)
    );
    pdr_host_model host (
        .i_ref_clk, .i_rst, .i_off_req(off_req), .i_host_mode(host_mode),
        .i_uv_warning(uvw), .o_servo_off_command(servo_off_command), .o_host_tlim(host_tlim)
    );
    //==========================================================
    // Compare and bus tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Request held until ack is seen, then released for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd_val = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk_word(rd_val, e);
    endtask
    // Restart pin is synchronised, so hold it a few cycles
    task automatic do_restart();
        @(posedge i_ref_clk);
        restart <= 1'b1;
        cycles(4);
        restart <= 1'b0;
        cycles(4);
    endtask
    // Off then on, so every trial starts from a clean state
    task automatic servo_on();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h1);
        cycles(4);
        chk_bit(motor, 1'b1);
        chk_bit(ready, 1'b1);
    endtask
    // Main supply low for n cycles; power must stand for the hold
    task automatic dip(input int n);
        int k;
        @(posedge i_ref_clk);
        main_ok <= 1'b0;
        for (k = 0; k < n; k++) begin
            @(posedge i_ref_clk);
            if (k < hold * MS) chk_bit(motor, 1'b1);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    //==========================================================
    // Clock and watchdog
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        num_errors++;
        end_of_test();
    end
    //==========================================================
    // Main sequence
    initial begin
        seed = 32'h5a99;
        {cyc, stb, we, restart, off_req, uv_alarm, host_mode} = 7'h0;
        {adr, sel, dat, main_ok, ctrl_ok} = {8'h0, 4'hf, 32'h0, 2'b11};
        {dc_bus, speed} = {16'hffff, 16'h0};
        {num_errors, cmp_count} = {32'h0, 32'h0};
        i_rst = 1'b1;
        cycles(10);
        i_rst <= 1'b0;
        // Defaults, a read past the last register, and out-of-range writes
        rd(OFS_HOLD, 32'h14);
        rd(OFS_UVSEL, 32'h0);
        rd(OFS_TLIM, 32'h32);
        rd(OFS_RMAX, 32'h2710);
        rd(OFS_LMAX, 32'h32);
        rd(OFS_ENCMAX, 32'h64);
        rd(8'h30, 32'h0);
        wr(OFS_HOLD, 32'h5);
        rd(OFS_HOLD, 32'h14);
        wr(OFS_REL, 32'h7d0);
        rd(OFS_REL, 32'h3e8);
        wr(OFS_TLIM, 32'h7f);
        rd(OFS_TLIM, 32'h64);
        // Short dip rides through, long dip cuts power until recovery
        hold = 20 + ($random(seed) & 15);
        wr(OFS_HOLD, 32'(hold));
        servo_on();
        dip(hold * MS - MS / 2);
        main_ok <= 1'b1;
        cycles(4);
        chk_bit(motor, 1'b1);
        dip((hold + 1) * MS + 6);
        chk_bit(motor, 1'b0);
        chk_bit(ready, 1'b0);
        main_ok <= 1'b1;
        cycles(4);
        chk_bit(motor, 1'b1);
        // Servo-off, control failure, undervoltage alarm, each mid-dip
        for (i = 0; i < 3; i++) begin
            servo_on();
            dip(MS);
            {off_req, ctrl_ok, uv_alarm} <= {i == 0, i != 1, i == 2};
            cycles(1);
            off_req <= 1'b0;
            cycles(3);
            chk_bit(motor, 1'b0);
            {main_ok, ctrl_ok, uv_alarm} <= 3'b110;
            cycles(4);
        end
        // Every undervoltage mode; restart-only settings wait for restart
        wr(OFS_UVTHR, 32'h3e8);
        wr(OFS_LMAX, 32'h19);
        rmax = 1000 + ($random(seed) & 4095);
        wr(OFS_RMAX, 32'(rmax));
        rd(OFS_ENCMAX, 32'h64);
        for (m = 0; m < 3; m++) begin
            wr(OFS_UVSEL, 32'(m));
            wr(OFS_UVSEL, 32'h3);
            host_mode <= (m == 1);
            do_restart();
            rd(OFS_UVSEL, 32'(m * 5));
            rd(OFS_ENCMAX, 32'hc8);
            tlim = $random(seed) & 63;
            wr(OFS_TLIM, 32'(tlim));
            wr(OFS_REL, 32'h3e8);
            @(posedge i_ref_clk);
            dc_bus <= 16'h3e8;
            cycles(4);
            chk_bit(uvw, m != 0);
            chk_bit(clamp, m == 2);
            chk_word(32'(tpct), (m == 2) ? 32'(tlim) : 32'h64);
            chk_bit(host_tlim, m == 1);
            @(posedge i_ref_clk);
            dc_bus <= 16'h3e9;
            cycles(4);
            chk_bit(uvw, 1'b0);
            chk_bit(host_tlim, 1'b0);
            cycles(997 * MS);
            chk_bit(clamp, m == 2);
            cycles(5 * MS);
            chk_bit(clamp, 1'b0);
        end
        // Speeds around the applied maximum; last two in linear mode, 25 x 100
        for (i = 0; i < 12; i++) begin
            if (i == 10) wr(OFS_CTRL, 32'h3);
            s = (i < 2) ? rmax + i : (i < 10) ? rmax - 8 + ($random(seed) & 15) : 2490 + i;
            @(posedge i_ref_clk);
            speed <= 16'(s);
            cycles(3);
            chk_bit(osp, s > ((i < 10) ? rmax : 2500));
        end
        rd(OFS_SPEED, 32'(s));
        end_of_test();
    end
endmodule // tb_top
